/* File: src/cef_pkg.sv */
package cef_pkg;
	// Avalon word addresses (byte address / 4)
	localparam int ADDR_W = 4;
	localparam logic [3:0] IDX_CONTROL = 4'h0;
	localparam logic [3:0] IDX_MODE = 4'h1;
	localparam logic [3:0] IDX_INSEL = 4'h2;
	localparam logic [3:0] IDX_RSTSRC = 4'h3;
	localparam logic [3:0] IDX_IRQ_STATUS = 4'h4;
	localparam logic [3:0] IDX_IRQ_MASK = 4'h5;
	// Printed control register offset, kept for reference
	localparam logic [7:0] CONTROL_PRINTED_OFFSET = 8'h9B;

	// Control register fields
	localparam int BIT_ENABLE = 7;
	localparam int BIT_OUTSTATE = 6;
	localparam int BIT_RISE = 5;
	localparam int BIT_FALL = 4;
	localparam int POS_HYST_HI = 3;
	localparam int POS_HYST_LO = 2;
	localparam int NEG_HYST_HI = 1;
	localparam int NEG_HYST_LO = 0;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [7:0] INSEL_RESET = 8'h77;
	localparam logic [1:0] IRQ_RESET = 2'h0;
	// Interrupt status bit positions
	localparam int IRQ_BIT_RISE = 1;
	localparam int IRQ_BIT_FALL = 0;

	typedef enum logic [1:0] {
		CEF_HYST_OFF,
		CEF_HYST_5MV,
		CEF_HYST_10MV,
		CEF_HYST_20MV
	} cef_hyst_t;

	// Settings that go to the analog core
	typedef struct packed {
		logic enable;
		cef_hyst_t pos_hyst;
		cef_hyst_t neg_hyst;
		logic [1:0] response_mode;
		logic [3:0] pos_input_sel;
		logic [3:0] neg_input_sel;
	} cef_analog_cfg_t;

	// Outputs toward pins and system
	typedef struct packed {
		logic latched_cmp_output;
		logic raw_cmp_output;
		logic osc_wake;
		logic reset_request;
	} cef_sys_out_t;
endpackage

/* File: src/cef_edge_detect.sv */
`timescale 1ns/100ps
`default_nettype none
module cef_edge_detect (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic async_in,
	output logic level_out,
	output logic rise_out,
	output logic fall_out
);
	logic meta_q, meta_d;
	logic sync_q, sync_d;
	logic prev_q, prev_d;

	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
		prev_d = sync_q;
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
		end
	end

	assign level_out = sync_q;
	assign rise_out = sync_q & ~prev_q;
	assign fall_out = ~sync_q & prev_q;
endmodule
`default_nettype wire

/* File: src/cef_comparator_ctrl.sv */
// How it works
// - A falling comparator output sets the fall edge flag in control bit 4.
// - A rising comparator output sets the rise edge flag in control bit 5.
// - Edge flags stay set until software writes them to 0; edges never clear them.
// - Both rising and falling edges raise interrupt requests.
// - Control bit 6 reads the present synchronised comparator level while enabled, and 0 while disabled.
// - Control bit 7 enables the comparator when 1, disables it when 0.
// - While disabled, the comparator outputs toward pins are forced low.
// - A latched clocked output and a raw unclocked output are offered for pins.
// - When enabled and the output is 0, the oscillator wake request is raised.
// - Control bits 3-2 select positive hysteresis, bits 1-0 negative hysteresis.
// - Each hysteresis field picks off, 5 mV, 10 mV or 20 mV.
// - A mode register holds the response time setting.
// - An input select register holds 4-bit positive and negative input fields.
// - The comparator output can be enabled as a system reset source.
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module cef_comparator_ctrl (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic [cef_pkg::ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic analog_cmp_in,
	output cef_pkg::cef_analog_cfg_t analog_cfg_out,
	output cef_pkg::cef_sys_out_t sys_out,
	output logic irq_out
);
	////////////////////////////////////////////////////////////////////
	// Registers
	logic enable_q, enable_d;
	logic rise_q, rise_d;
	logic fall_q, fall_d;
	logic [1:0] pos_hyst_q, pos_hyst_d;
	logic [1:0] neg_hyst_q, neg_hyst_d;
	logic [1:0] mode_q, mode_d;
	logic [7:0] insel_q, insel_d;
	logic rst_src_q, rst_src_d;
	logic [1:0] irq_stat_q, irq_stat_d;
	logic [1:0] irq_mask_q, irq_mask_d;
	logic latched_q, latched_d;
	logic ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;

	logic cmp_level, cmp_rise, cmp_fall;
	logic wr_hit, rd_hit;
	logic [7:0] wb;
	logic [7:0] control_view;

	////////////////////////////////////////////////////////////////////
	// Comparator sampling
	cef_edge_detect u_edge (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.async_in(analog_cmp_in),
		.level_out(cmp_level),
		.rise_out(cmp_rise),
		.fall_out(cmp_fall)
	);

	////////////////////////////////////////////////////////////////////
	// Avalon slave: one wait state, answer in second cycle
	// Writes land only at the edge that accepts them
	assign wr_hit = avs_write_in & ack_q;
	assign rd_hit = avs_read_in & ~ack_q;
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
	assign wb = avs_byteenable_in[0] ? avs_writedata_in[7:0] : 8'h00;

	always_comb begin
		control_view = 8'h00;
		control_view[cef_pkg::BIT_ENABLE] = enable_q;
		control_view[cef_pkg::BIT_OUTSTATE] = cmp_level & enable_q;
		control_view[cef_pkg::BIT_RISE] = rise_q;
		control_view[cef_pkg::BIT_FALL] = fall_q;
		control_view[cef_pkg::POS_HYST_HI:cef_pkg::POS_HYST_LO] = pos_hyst_q;
		control_view[cef_pkg::NEG_HYST_HI:cef_pkg::NEG_HYST_LO] = neg_hyst_q;
	end

	always_comb begin
		enable_d = enable_q;
		rise_d = rise_q;
		fall_d = fall_q;
		pos_hyst_d = pos_hyst_q;
		neg_hyst_d = neg_hyst_q;
		mode_d = mode_q;
		insel_d = insel_q;
		rst_src_d = rst_src_q;
		irq_mask_d = irq_mask_q;
		irq_stat_d = irq_stat_q;
		ack_d = (avs_read_in | avs_write_in) & ~ack_q;
		rdata_d = rdata_q;
		if (wr_hit && avs_byteenable_in[0]) begin
			case (avs_address_in)
				cef_pkg::IDX_CONTROL: begin
					enable_d = wb[cef_pkg::BIT_ENABLE];
					rise_d = wb[cef_pkg::BIT_RISE];
					fall_d = wb[cef_pkg::BIT_FALL];
					pos_hyst_d = wb[cef_pkg::POS_HYST_HI:cef_pkg::POS_HYST_LO];
					neg_hyst_d = wb[cef_pkg::NEG_HYST_HI:cef_pkg::NEG_HYST_LO];
				end
				cef_pkg::IDX_MODE: mode_d = wb[1:0];
				cef_pkg::IDX_INSEL: insel_d = wb;
				cef_pkg::IDX_RSTSRC: rst_src_d = wb[0];
				cef_pkg::IDX_IRQ_STATUS: irq_stat_d = irq_stat_q & ~wb[1:0];
				cef_pkg::IDX_IRQ_MASK: irq_mask_d = wb[1:0];
				default: ;
			endcase
		end
		// rising edge sets flag, wins over clear
		if (cmp_rise && enable_q) begin
			rise_d = 1'b1;
			irq_stat_d[cef_pkg::IRQ_BIT_RISE] = 1'b1;
		end
		// falling edge sets flag, wins over clear
		if (cmp_fall && enable_q) begin
			fall_d = 1'b1;
			irq_stat_d[cef_pkg::IRQ_BIT_FALL] = 1'b1;
		end
		if (rd_hit) begin
			case (avs_address_in)
				cef_pkg::IDX_CONTROL: rdata_d = {24'h000000, control_view};
				cef_pkg::IDX_MODE: rdata_d = {30'h0, mode_q};
				cef_pkg::IDX_INSEL: rdata_d = {24'h000000, insel_q};
				cef_pkg::IDX_RSTSRC: rdata_d = {31'h0, rst_src_q};
				cef_pkg::IDX_IRQ_STATUS: rdata_d = {30'h0, irq_stat_q};
				cef_pkg::IDX_IRQ_MASK: rdata_d = {30'h0, irq_mask_q};
				default: rdata_d = 32'h00000000;
			endcase
		end
		latched_d = cmp_level;
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			enable_q <= cef_pkg::CONTROL_RESET[cef_pkg::BIT_ENABLE];
			rise_q <= cef_pkg::CONTROL_RESET[cef_pkg::BIT_RISE];
			fall_q <= cef_pkg::CONTROL_RESET[cef_pkg::BIT_FALL];
			pos_hyst_q <= cef_pkg::CONTROL_RESET[cef_pkg::POS_HYST_HI:cef_pkg::POS_HYST_LO];
			neg_hyst_q <= cef_pkg::CONTROL_RESET[cef_pkg::NEG_HYST_HI:cef_pkg::NEG_HYST_LO];
			mode_q <= cef_pkg::MODE_RESET;
			insel_q <= cef_pkg::INSEL_RESET;
			rst_src_q <= 1'b0;
			irq_stat_q <= cef_pkg::IRQ_RESET;
			irq_mask_q <= cef_pkg::IRQ_RESET;
			latched_q <= 1'b0;
			ack_q <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			enable_q <= enable_d;
			rise_q <= rise_d;
			fall_q <= fall_d;
			pos_hyst_q <= pos_hyst_d;
			neg_hyst_q <= neg_hyst_d;
			mode_q <= mode_d;
			insel_q <= insel_d;
			rst_src_q <= rst_src_d;
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			latched_q <= latched_d;
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs
	assign avs_readdata_out = rdata_q;
	assign irq_out = |(irq_stat_q & irq_mask_q);

	always_comb begin
		analog_cfg_out.enable = enable_q;
		analog_cfg_out.pos_hyst = cef_pkg::cef_hyst_t'(pos_hyst_q);
		analog_cfg_out.neg_hyst = cef_pkg::cef_hyst_t'(neg_hyst_q);
		analog_cfg_out.response_mode = mode_q;
		analog_cfg_out.pos_input_sel = insel_q[3:0];
		analog_cfg_out.neg_input_sel = insel_q[7:4];
		sys_out.latched_cmp_output = latched_q & enable_q;
		sys_out.raw_cmp_output = analog_cmp_in & enable_q;
		sys_out.osc_wake = enable_q & ~analog_cmp_in;
		sys_out.reset_request = rst_src_q & enable_q & ~cmp_level;
	end
endmodule
`default_nettype wire

/* File: bench/cef_comparator_ctrl_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module cef_comparator_ctrl_assertions (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic [cef_pkg::ADDR_W-1:0] avs_address_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	input wire logic avs_waitrequest_out,
	input wire logic analog_cmp_in,
	input wire cef_pkg::cef_analog_cfg_t analog_cfg_out,
	input wire cef_pkg::cef_sys_out_t sys_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	logic wr_ok;
	assign wr_ok = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
	pin_low_off_a: assert property (!analog_cfg_out.enable |-> !sys_out.raw_cmp_output)
		else $error("raw output not low");
	latched_low_a: assert property (!analog_cfg_out.enable [*4] |-> !sys_out.latched_cmp_output)
		else $error("latched output not low");
	raw_follow_a: assert property (analog_cfg_out.enable |-> sys_out.raw_cmp_output == analog_cmp_in)
		else $error("raw output wrong");
	latched_track_a: assert property ((analog_cfg_out.enable && $stable(analog_cmp_in)) [*4]
		|-> sys_out.latched_cmp_output == analog_cmp_in)
		else $error("latched output wrong");
	osc_wake_a: assert property (sys_out.osc_wake == (analog_cfg_out.enable && !analog_cmp_in))
		else $error("wake wrong");
	enable_write_a: assert property (wr_ok && avs_address_in == cef_pkg::IDX_CONTROL
		|=> analog_cfg_out.enable == $past(avs_writedata_in[7]))
		else $error("enable not stored");
	hyst_write_a: assert property (wr_ok && avs_address_in == cef_pkg::IDX_CONTROL
		|=> {analog_cfg_out.pos_hyst, analog_cfg_out.neg_hyst} == $past(avs_writedata_in[3:0]))
		else $error("hysteresis not stored");
	insel_write_a: assert property (wr_ok && avs_address_in == cef_pkg::IDX_INSEL
		|=> {analog_cfg_out.neg_input_sel, analog_cfg_out.pos_input_sel} == $past(avs_writedata_in[7:0]))
		else $error("input select not stored");
	cover property (analog_cfg_out.enable && $rose(analog_cmp_in));
	cover property (analog_cfg_out.enable && $fell(analog_cmp_in));
	cover property (sys_out.reset_request);
endmodule
bind cef_comparator_ctrl cef_comparator_ctrl_assertions chk (.clock_in, .rst_n_in, .avs_address_in, .avs_write_in,
	.avs_writedata_in, .avs_byteenable_in, .avs_waitrequest_out, .analog_cmp_in, .analog_cfg_out, .sys_out);
`default_nettype wire

/* File: bench/cef_analog_model.sv */
`timescale 1ns/100ps
`default_nettype none
module cef_analog_model (
	input wire logic clock_in,
	output logic cmp_out
);
	logic level_q = 1'h0;
	assign cmp_out = level_q;
	task automatic set_level(input logic v);
		@(posedge clock_in);
		level_q <= v;
	endtask
endmodule
`default_nettype wire

/* File: bench/test_cef_comparator_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module test_cef_comparator_ctrl;
	logic clock_in = 1'h0;
	logic rst_n_in = 1'h0;
	logic [3:0] avs_address_in = 4'h0;
	logic avs_read_in = 1'h0;
	logic avs_write_in = 1'h0;
	logic [31:0] avs_writedata_in = 32'h0;
	logic [3:0] avs_byteenable_in = 4'hF;
	logic [31:0] avs_readdata_out, q;
	logic avs_waitrequest_out, analog_cmp_in, irq_out;
	cef_pkg::cef_analog_cfg_t analog_cfg_out;
	cef_pkg::cef_sys_out_t sys_out;
	int bad_count = 0;
	int cmp_count = 0;
	cef_comparator_ctrl dut (.clock_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
		.avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .analog_cmp_in, .analog_cfg_out,
		.sys_out, .irq_out);
	cef_analog_model ana (.clock_in, .cmp_out(analog_cmp_in));
	initial begin
		forever #20 clock_in = ~clock_in;
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic [3:0] a, input logic w, input logic [7:0] d);
		int n;
		n = 0;
		avs_address_in <= a;
		avs_write_in <= w;
		avs_read_in <= !w;
		avs_writedata_in <= {24'h0, d};
		do begin
			@(posedge clock_in);
			n++;
		end while (avs_waitrequest_out !== 1'h0 && n < 50);
		if (avs_waitrequest_out !== 1'h0) begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, avs_waitrequest_out, 1'h0);
		end
		q = avs_readdata_out;
		avs_write_in <= 1'h0;
		avs_read_in <= 1'h0;
		@(posedge clock_in);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		acc(a, 1'h0, 8'h0);
		chk(q, {24'h0, e});
	endtask
	task automatic settle(input logic v);
		ana.set_level(v);
		repeat (4) @(posedge clock_in);
	endtask
	initial begin
		repeat (2000) @(posedge clock_in);
		bad_count++;
		test_done;
	end
	initial begin
		repeat (4) @(posedge clock_in);
		rst_n_in <= 1'h1;
		@(posedge clock_in);
		rd(4'h0, 8'h00);
		rd(4'h2, 8'h77);
		acc(4'hF, 1'h1, 8'hFF);
		rd(4'hF, 8'h00);
		avs_byteenable_in <= 4'h0;
		acc(4'h2, 1'h1, 8'h00);
		avs_byteenable_in <= 4'hF;
		rd(4'h2, 8'h77);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			acc(4'h0, 1'h1, 8'h80 | 8'(i * 5));
			rd(4'h0, 8'h80 | 8'(i * 5));
			chk(32'(analog_cfg_out.pos_hyst), 32'(i));
			chk(32'(analog_cfg_out.neg_hyst), 32'(i));
		end
		acc(4'h2, 1'h1, 8'hA5);
		rd(4'h2, 8'hA5);
		chk({24'h0, analog_cfg_out.neg_input_sel, analog_cfg_out.pos_input_sel}, 32'hA5);
		acc(4'h1, 1'h1, 8'h02);
		rd(4'h1, 8'h02);
		chk(32'(analog_cfg_out.response_mode), 32'h2);
		$display("test config done");
		acc(4'h5, 1'h1, 8'h03);
		acc(4'h0, 1'h1, 8'h80);
		settle(1'h1);
		rd(4'h0, 8'hE0);
		chk({31'h0, irq_out}, 32'h1);
		chk({30'h0, sys_out.latched_cmp_output, sys_out.raw_cmp_output}, 32'h3);
		settle(1'h0);
		rd(4'h0, 8'hB0);
		rd(4'h4, 8'h03);
		chk({31'h0, sys_out.osc_wake}, 32'h1);
		acc(4'h4, 1'h1, 8'h03);
		chk({31'h0, irq_out}, 32'h0);
		acc(4'h5, 1'h1, 8'h00);
		settle(1'h1);
		chk({31'h0, irq_out}, 32'h0);
		rd(4'h4, 8'h02);
		acc(4'h0, 1'h1, 8'h80);
		rd(4'h0, 8'hC0);
		$display("test edges done");
		acc(4'h3, 1'h1, 8'h01);
		acc(4'h0, 1'h1, 8'h00);
		repeat (4) @(posedge clock_in);
		chk({28'h0, sys_out}, 32'h0);
		rd(4'h0, 8'h00);
		ana.set_level(1'h0);
		acc(4'h0, 1'h1, 8'h80);
		repeat (4) @(posedge clock_in);
		chk({31'h0, sys_out.reset_request}, 32'h1);
		$display("test disable done");
		test_done;
	end
endmodule
`default_nettype wire
